// ==== vsw_map.svh ====
`ifndef VSW_MAP_SVH
`define VSW_MAP_SVH

// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define VSW_CLK_PERIOD_NS  25
`define VSW_PD_MIN_NS      150
`define VSW_PD_MIN_CYC     \
  ((`VSW_PD_MIN_NS + `VSW_CLK_PERIOD_NS - 1) / `VSW_CLK_PERIOD_NS)
`define VSW_BUF_MIN_NS     1300
`define VSW_BUF_MIN_CYC    \
  ((`VSW_BUF_MIN_NS + `VSW_CLK_PERIOD_NS - 1) / `VSW_CLK_PERIOD_NS)
`define VSW_SPIKE_MAX_NS   50
`define VSW_SPIKE_MAX_CYC  \
  ((`VSW_SPIKE_MAX_NS / `VSW_CLK_PERIOD_NS) < 1 ? 1 : \
   (`VSW_SPIKE_MAX_NS / `VSW_CLK_PERIOD_NS))

// ------------------------------------------------------------
// device control registers (link register port)
// ------------------------------------------------------------
`define VSW_DREG_SEL_A     5'h00
`define VSW_DREG_SEL_B     5'h01
`define VSW_SEL_RESET      3'h0
`define VSW_SEL_OFF        3'h0

// ------------------------------------------------------------
// host apb registers
// ------------------------------------------------------------
`define VSW_HREG_CTRL      12'h000
`define VSW_HREG_CMD       12'h004
`define VSW_HREG_STATUS    12'h008
`define VSW_CTRL_RESET     32'h0000_3000
`define VSW_CTRL_RELEASE   0
`define VSW_CTRL_PARALLEL  1
`define VSW_CTRL_SEL_A_LSB 4
`define VSW_CTRL_SEL_B_LSB 8
`define VSW_CTRL_CLK_LINE  12
`define VSW_CTRL_DATA_LINE 13
`define VSW_CMD_WRITE      0
`define VSW_CMD_ADDR_LSB   8
`define VSW_CMD_DATA_LSB   16
`define VSW_ST_BUSY        0
`define VSW_ST_REFUSED     1
`define VSW_ST_DONE        2
`define VSW_ST_PDN         3
`define VSW_ST_RDATA_LSB   8

`endif

// ==== vsw_pkg.sv ====
package vsw_pkg;

  typedef logic [2:0] vsw_sel_t;
  typedef logic [4:0] vsw_addr_t;
  typedef logic [7:0] vsw_data_t;

  typedef enum logic [1:0] {
    VSW_H_IDLE,
    VSW_H_REQ,
    VSW_H_GAP
  } vsw_host_state_t;

endpackage : vsw_pkg

// ==== vsw_if.sv ====
interface vsw_if;
  import vsw_pkg::*;

  // ------------------------------------------------------------
  // mode and select pins
  // ------------------------------------------------------------
  logic      powerdown_pin_active_low;
  logic      parallel_mode;
  vsw_sel_t  first_source_select;
  vsw_sel_t  second_source_select;

  // ------------------------------------------------------------
  // register access port
  // ------------------------------------------------------------
  logic      reg_req;
  logic      reg_we;
  vsw_addr_t reg_addr;
  vsw_data_t reg_wdata;
  logic      reg_ack;
  logic      reg_refused;
  vsw_data_t reg_rdata;

  // ------------------------------------------------------------
  // raw two-wire lines
  // ------------------------------------------------------------
  logic      bus_clk_line;
  logic      bus_data_line;

  modport dev (
    input  powerdown_pin_active_low,
    input  parallel_mode,
    input  first_source_select,
    input  second_source_select,
    input  reg_req,
    input  reg_we,
    input  reg_addr,
    input  reg_wdata,
    output reg_ack,
    output reg_refused,
    output reg_rdata,
    input  bus_clk_line,
    input  bus_data_line
  );

  modport host (
    output powerdown_pin_active_low,
    output parallel_mode,
    output first_source_select,
    output second_source_select,
    output reg_req,
    output reg_we,
    output reg_addr,
    output reg_wdata,
    input  reg_ack,
    input  reg_refused,
    input  reg_rdata,
    output bus_clk_line,
    output bus_data_line
  );

endinterface : vsw_if

// ==== vsw_dev.sv ====
// Summary of operation
// - power-down low grounds both video outputs
// - mode pin high takes selects from pins
// - parallel mode refuses every register access
// - first pin select: zero off, else input
// - second pin select decodes the same way
// - first negative supply off when down or zero
// - second supply and output off when down/zero
// - mode pin low takes selects from registers
// - first field zero grounds output, supply off
// - second field zero grounds output, supply off
// - power-down low clears every control register
// - host holds power-down low at power-up
// - parallel mode needs no power-up reset pulse
// - power-down low pulse lasts at least 150 ns
// - two-wire bus idle 1.3 us between frames
// - spikes up to 50 ns filtered on lines
// - field codes one..seven route inputs one..seven
`include "vsw_map.svh"

module vsw_dev
  import vsw_pkg::*;
#(
  parameter int SPIKE_CYC = `VSW_SPIKE_MAX_CYC
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // link to host
  vsw_if.dev        link,
  // video switch controls
  output vsw_sel_t  video_route_a,
  output vsw_sel_t  video_route_b,
  output logic      out_ground_a,
  output logic      out_ground_b,
  output logic      neg_supply_a,
  output logic      neg_supply_b,
  // mode status
  output logic      powered_down,
  output logic      serial_mode,
  // filtered two-wire lines
  output logic      bus_clk_clean,
  output logic      bus_data_clean
);

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // a select reaches the output only while powered up and nonzero
  function automatic vsw_sel_t route_of(input logic pdn_n,
                                        input vsw_sel_t sel);
    route_of = pdn_n ? sel : `VSW_SEL_OFF;
  endfunction : route_of

  function automatic logic active_of(input logic pdn_n,
                                     input vsw_sel_t sel);
    active_of = pdn_n && (sel != `VSW_SEL_OFF);
  endfunction : active_of

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  vsw_sel_t  field_a;
  vsw_sel_t  field_b;
  logic      access_ok;
  logic      access_new;

  // parallel mode or power-down refuses the port
  assign access_ok  = !link.parallel_mode
                      && link.powerdown_pin_active_low;
  assign access_new = link.reg_req && !link.reg_ack;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      field_a <= `VSW_SEL_RESET;
      field_b <= `VSW_SEL_RESET;
    end else if (!link.powerdown_pin_active_low) begin
      field_a <= `VSW_SEL_RESET;
      field_b <= `VSW_SEL_RESET;
    end else if (access_new && access_ok && link.reg_we) begin
      if (link.reg_addr == `VSW_DREG_SEL_A) begin
        field_a <= link.reg_wdata[2:0];
      end
      if (link.reg_addr == `VSW_DREG_SEL_B) begin
        field_b <= link.reg_wdata[2:0];
      end
    end
  end

  // ------------------------------------------------------------
  // register access answer
  // ------------------------------------------------------------
  vsw_data_t next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    if (access_ok && !link.reg_we) begin
      if (link.reg_addr == `VSW_DREG_SEL_A) begin
        next_rdata = {5'h00, field_a};
      end else if (link.reg_addr == `VSW_DREG_SEL_B) begin
        next_rdata = {5'h00, field_b};
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      link.reg_ack     <= 1'b0;
      link.reg_refused <= 1'b0;
      link.reg_rdata   <= 8'h00;
    end else begin
      link.reg_ack <= access_new;
      if (access_new) begin
        link.reg_refused <= !access_ok;
        link.reg_rdata   <= next_rdata;
      end
    end
  end

  // ------------------------------------------------------------
  // source selection per channel
  // ------------------------------------------------------------
  vsw_sel_t  code_a;
  vsw_sel_t  code_b;

  always_comb begin
    if (link.parallel_mode) begin
      code_a = link.first_source_select;
      code_b = link.second_source_select;
    end else begin
      code_a = field_a;
      code_b = field_b;
    end
  end

  // ------------------------------------------------------------
  // output channel drive
  // ------------------------------------------------------------
  // codes 1..7 pass straight through as input numbers 1..7
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      video_route_a <= `VSW_SEL_OFF;
      out_ground_a  <= 1'b1;
      neg_supply_a  <= 1'b0;
    end else begin
      video_route_a <= route_of(link.powerdown_pin_active_low,
                                code_a);
      out_ground_a  <= !active_of(link.powerdown_pin_active_low,
                                  code_a);
      neg_supply_a  <= active_of(link.powerdown_pin_active_low,
                                 code_a);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      video_route_b <= `VSW_SEL_OFF;
      out_ground_b  <= 1'b1;
      neg_supply_b  <= 1'b0;
    end else begin
      video_route_b <= route_of(link.powerdown_pin_active_low,
                                code_b);
      out_ground_b  <= !active_of(link.powerdown_pin_active_low,
                                  code_b);
      neg_supply_b  <= active_of(link.powerdown_pin_active_low,
                                 code_b);
    end
  end

  // ------------------------------------------------------------
  // mode status
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      powered_down <= 1'b1;
      serial_mode  <= 1'b0;
    end else begin
      powered_down <= !link.powerdown_pin_active_low;
      serial_mode  <= !link.parallel_mode;
    end
  end

  // ------------------------------------------------------------
  // spike filter on the two-wire lines
  // ------------------------------------------------------------
  // a level must hold SPIKE_CYC+1 samples before it is passed on
  localparam int CW = $clog2(SPIKE_CYC + 2);

  logic [1:0] line_raw;
  wire  [1:0] line_clean;

  assign line_raw       = {link.bus_data_line, link.bus_clk_line};
  assign bus_clk_clean  = line_clean[0];
  assign bus_data_clean = line_clean[1];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filt
      logic [CW-1:0] stable_cnt;
      logic          clean_q;

      // one driver per bit: each lane owns its own flop
      assign line_clean[gi] = clean_q;

      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          stable_cnt <= '0;
          clean_q    <= 1'b1;
        end else if (line_raw[gi] == clean_q) begin
          stable_cnt <= '0;
        end else if (stable_cnt == CW'(SPIKE_CYC)) begin
          stable_cnt <= '0;
          clean_q    <= line_raw[gi];
        end else begin
          stable_cnt <= stable_cnt + CW'(1);
        end
      end
    end
  endgenerate

endmodule : vsw_dev

// ==== vsw_host.sv ====
// Chosen here: the APB slave port and the register addresses.
`include "vsw_map.svh"

module vsw_host
  import vsw_pkg::*;
#(
  parameter int PD_CYC  = `VSW_PD_MIN_CYC,
  parameter int BUF_CYC = `VSW_BUF_MIN_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link to device
  vsw_if.host              link
);

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic        acc;
  logic        wr;
  logic        mapped;
  logic [31:0] ctrl;
  logic        st_refused;
  logic        st_done;
  vsw_data_t   st_rdata;
  vsw_host_state_t state;
  logic [31:0] next_prdata;

  assign acc    = psel && penable && !pready;
  assign wr     = psel && penable && pready && pwrite;
  assign mapped = (paddr == `VSW_HREG_CTRL) || (paddr == `VSW_HREG_CMD)
                  || (paddr == `VSW_HREG_STATUS);

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (paddr == `VSW_HREG_CTRL) begin
      next_prdata = ctrl;
    end else if (paddr == `VSW_HREG_STATUS) begin
      next_prdata[`VSW_ST_BUSY]    = (state != VSW_H_IDLE);
      next_prdata[`VSW_ST_REFUSED] = st_refused;
      next_prdata[`VSW_ST_DONE]    = st_done;
      next_prdata[`VSW_ST_PDN]     = link.powerdown_pin_active_low;
      next_prdata[`VSW_ST_RDATA_LSB +: 8] = st_rdata;
    end
  end

  // one wait state on every transfer
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc;
      pslverr <= acc && !mapped;
      if (acc) begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= `VSW_CTRL_RESET;
    end else if (wr && paddr == `VSW_HREG_CTRL) begin
      ctrl <= pwdata;
    end
  end

  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  localparam int PW = $clog2(PD_CYC + 1);
  logic [PW-1:0] pd_cnt;

  // release only after the low phase has lasted PD_CYC cycles
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pd_cnt                        <= '0;
      link.powerdown_pin_active_low <= 1'b0;
    end else begin
      if (!ctrl[`VSW_CTRL_RELEASE]) begin
        pd_cnt <= '0;
      end else if (pd_cnt != PW'(PD_CYC)) begin
        pd_cnt <= pd_cnt + PW'(1);
      end
      link.powerdown_pin_active_low <= ctrl[`VSW_CTRL_RELEASE]
                                       && (pd_cnt == PW'(PD_CYC));
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      link.parallel_mode        <= 1'b0;
      link.first_source_select  <= `VSW_SEL_OFF;
      link.second_source_select <= `VSW_SEL_OFF;
      link.bus_clk_line         <= 1'b1;
      link.bus_data_line        <= 1'b1;
    end else begin
      link.parallel_mode        <= ctrl[`VSW_CTRL_PARALLEL];
      link.first_source_select  <= ctrl[`VSW_CTRL_SEL_A_LSB +: 3];
      link.second_source_select <= ctrl[`VSW_CTRL_SEL_B_LSB +: 3];
      link.bus_clk_line         <= ctrl[`VSW_CTRL_CLK_LINE];
      link.bus_data_line        <= ctrl[`VSW_CTRL_DATA_LINE];
    end
  end

  // ------------------------------------------------------------
  // register command sequencer
  // ------------------------------------------------------------
  localparam int GW = $clog2(BUF_CYC + 1);
  logic [GW-1:0] gap_cnt;
  logic          cmd_go;
  logic          st_clr;

  assign cmd_go = wr && (paddr == `VSW_HREG_CMD) && (state == VSW_H_IDLE);
  assign st_clr = wr && (paddr == `VSW_HREG_STATUS);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state          <= VSW_H_IDLE;
      gap_cnt        <= '0;
      link.reg_req   <= 1'b0;
      link.reg_we    <= 1'b0;
      link.reg_addr  <= 5'h00;
      link.reg_wdata <= 8'h00;
    end else begin
      case (state)
        VSW_H_IDLE: begin
          if (cmd_go) begin
            link.reg_req   <= 1'b1;
            link.reg_we    <= pwdata[`VSW_CMD_WRITE];
            link.reg_addr  <= pwdata[`VSW_CMD_ADDR_LSB +: 5];
            link.reg_wdata <= pwdata[`VSW_CMD_DATA_LSB +: 8];
            state          <= VSW_H_REQ;
          end
        end
        VSW_H_REQ: begin
          if (link.reg_ack) begin
            link.reg_req <= 1'b0;
            gap_cnt      <= '0;
            state        <= VSW_H_GAP;
          end
        end
        VSW_H_GAP: begin
          if (gap_cnt == GW'(BUF_CYC - 1)) begin
            state <= VSW_H_IDLE;
          end else begin
            gap_cnt <= gap_cnt + GW'(1);
          end
        end
        default: begin
          state        <= VSW_H_IDLE;
          link.reg_req <= 1'b0;
        end
      endcase
    end
  end

  // sticky status; a set in the clearing cycle wins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_refused <= 1'b0;
      st_done    <= 1'b0;
      st_rdata   <= 8'h00;
    end else if (state == VSW_H_REQ && link.reg_ack) begin
      st_done    <= 1'b1;
      st_refused <= link.reg_refused || st_refused;
      st_rdata   <= link.reg_rdata;
    end else if (st_clr) begin
      st_done    <= st_done && !pwdata[`VSW_ST_DONE];
      st_refused <= st_refused && !pwdata[`VSW_ST_REFUSED];
    end
  end

endmodule : vsw_host

// ==== vsw_props.sv ====
// ------------------------------------------------------------
// link and output checks
// ------------------------------------------------------------
module vsw_props
  import vsw_pkg::*;
(
  // clock and reset
  input wire logic      mclk,
  input wire logic      resetn,
  // link pins
  input wire logic      powerdown_pin_active_low,
  input wire logic      parallel_mode,
  input wire vsw_sel_t  first_source_select,
  input wire vsw_sel_t  second_source_select,
  input wire logic      reg_req,
  input wire logic      reg_we,
  input wire vsw_addr_t reg_addr,
  input wire vsw_data_t reg_wdata,
  input wire logic      reg_ack,
  input wire logic      reg_refused,
  input wire vsw_data_t reg_rdata,
  input wire logic      bus_clk_line,
  // device outputs
  input wire vsw_sel_t  video_route_a,
  input wire vsw_sel_t  video_route_b,
  input wire logic      out_ground_a,
  input wire logic      out_ground_b,
  input wire logic      neg_supply_a,
  input wire logic      neg_supply_b,
  input wire logic      bus_clk_clean
);
  logic up;
  assign up = powerdown_pin_active_low;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_pd_ground;
    (!up)[*3] |-> out_ground_a && out_ground_b && !neg_supply_a
      && !neg_supply_b;
  endproperty
  a_pd_ground: assert property (p_pd_ground)
    else $error("output live while powered down");

  property p_par_a;
    (parallel_mode && up && $stable(first_source_select))[*3]
      |-> video_route_a == first_source_select
      && out_ground_a == (first_source_select == 3'h0)
      && neg_supply_a == (first_source_select != 3'h0);
  endproperty
  a_par_a: assert property (p_par_a)
    else $error("first pin select decoded wrongly");

  property p_par_b;
    (parallel_mode && up && $stable(second_source_select))[*3]
      |-> video_route_b == second_source_select
      && out_ground_b == (second_source_select == 3'h0)
      && neg_supply_b == (second_source_select != 3'h0);
  endproperty
  a_par_b: assert property (p_par_b)
    else $error("second pin select decoded wrongly");

  property p_refuse;
    reg_ack && $past(parallel_mode) |-> reg_refused && reg_rdata == 8'h00;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("register access taken in pin mode");

  property p_ser_ok;
    reg_ack && !$past(parallel_mode) && $past(up) |-> !reg_refused;
  endproperty
  a_ser_ok: assert property (p_ser_ok)
    else $error("register access refused in serial mode");

  property p_live;
    (video_route_a != 3'h0 |-> !out_ground_a && neg_supply_a)
      and (video_route_b != 3'h0 |-> !out_ground_b && neg_supply_b);
  endproperty
  a_live: assert property (p_live)
    else $error("routed output grounded or supply off");

  property p_write;
    reg_ack && !reg_refused && reg_we && reg_addr[4:1] == 4'h0
      && !parallel_mode |-> ##2
      (reg_addr[0] ? video_route_b : video_route_a) == reg_wdata[2:0];
  endproperty
  a_write: assert property (p_write)
    else $error("written field not on outputs");

  property p_clear;
    $rose(up) && !parallel_mode |-> ##3
      video_route_a == 3'h0 && video_route_b == 3'h0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("fields survive power-down");

  property p_filter;
    $changed(bus_clk_clean) |-> $past(bus_clk_line) == bus_clk_clean
      && $past(bus_clk_line, 2) == bus_clk_clean
      && $past(bus_clk_line, 3) == bus_clk_clean;
  endproperty
  a_filter: assert property (p_filter)
    else $error("clean line moved on a short pulse");

  // bench runs the host with a six-cycle low phase
  property p_pd_len;
    $fell(up) |-> (!up)[*6];
  endproperty
  a_pd_len: assert property (p_pd_len)
    else $error("power-down pulse too short");

  // bench runs the host with a four-cycle idle gap
  property p_gap;
    $fell(reg_req) |-> (!reg_req)[*4];
  endproperty
  a_gap: assert property (p_gap)
    else $error("link request inside idle gap");

  c_par: cover property (parallel_mode && video_route_b == 3'h7);
  c_wr: cover property (reg_ack && reg_we && !reg_refused);
  c_ref: cover property (reg_ack && reg_refused);
endmodule : vsw_props

// ==== tb_video_switch_mode_control.sv ====
`include "vsw_map.svh"

module tb_video_switch_mode_control;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, serr;
  logic [2:0]  video_route_a, video_route_b;
  logic        out_ground_a, out_ground_b, neg_supply_a, neg_supply_b;
  logic        bus_clk_clean, bus_data_clean;
  logic        powered_down, serial_mode;
  int          err_count = 0;
  int          comparisons = 0;

  vsw_if link ();
  vsw_host #(.PD_CYC(6), .BUF_CYC(4)) i_vsw_host (.mclk, .resetn, .paddr,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .link);
  vsw_dev #(.SPIKE_CYC(2)) i_vsw_dev (.mclk, .resetn, .link, .video_route_a,
    .video_route_b, .out_ground_a, .out_ground_b, .neg_supply_a,
    .neg_supply_b, .powered_down, .serial_mode, .bus_clk_clean,
    .bus_data_clean);
  vsw_props i_vsw_props (.mclk, .resetn,
    .powerdown_pin_active_low(link.powerdown_pin_active_low),
    .parallel_mode(link.parallel_mode),
    .first_source_select(link.first_source_select),
    .second_source_select(link.second_source_select),
    .reg_req(link.reg_req),
    .reg_we(link.reg_we), .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata), .reg_ack(link.reg_ack),
    .reg_refused(link.reg_refused), .reg_rdata(link.reg_rdata),
    .bus_clk_line(link.bus_clk_line), .video_route_a, .video_route_b,
    .out_ground_a, .out_ground_b, .neg_supply_a, .neg_supply_b,
    .bus_clk_clean);

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic hang();
    err_count++;
    $display("wrong value at %0t: no answer", $time);
    finish_test();
  endtask : hang

  // ------------------------------------------------------------
  // apb master and link commands
  // ------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (n > 50) hang();
    end while (pready !== 1'b1);
    // answer taken at the completing edge, request released after it
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, `VSW_HREG_STATUS, 32'h0);
      n++;
      if (n > 200) hang();
    end while (rd[b] !== v);
  endtask : poll

  task automatic cmd(input logic we, input logic [4:0] a,
                     input logic [7:0] d);
    poll(0, 1'b0);
    apb(1'b1, `VSW_HREG_STATUS, 32'h6);
    apb(1'b1, `VSW_HREG_CMD, {8'h0, d, 3'h0, a, 7'h0, we});
    poll(2, 1'b1);
  endtask : cmd

  task automatic out_chk(input logic [2:0] a, input logic [2:0] b);
    chk(32'({video_route_a, out_ground_a, neg_supply_a}),
        32'({a, a == 3'h0, a != 3'h0}));
    chk(32'({video_route_b, out_ground_b, neg_supply_b}),
        32'({b, b == 3'h0, b != 3'h0}));
  endtask : out_chk

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, `VSW_HREG_CTRL, 32'h0);
    chk(rd, 32'h0000_3000);
    apb(1'b0, `VSW_HREG_STATUS, 32'h0);
    chk(rd, 32'h0);
    chk(32'({powered_down, serial_mode}), 32'h3);
    out_chk(3'h0, 3'h0);
    apb(1'b0, 12'hffc, 32'h0);
    chk({rd[30:0], serr}, 32'h1);
  endtask : t_reset

  task automatic t_parallel();
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, `VSW_HREG_CTRL, 32'h3003 | (k << 4) | ((7 - k) << 8));
      poll(3, 1'b1);
      repeat (4) @(posedge mclk);
      out_chk(3'(k), 3'(7 - k));
    end
    cmd(1'b1, 5'h00, 8'h02);
    chk(32'(rd[1]), 32'h1);
    out_chk(3'h7, 3'h0);
    chk(32'({powered_down, serial_mode}), 32'h0);
  endtask : t_parallel

  task automatic t_serial();
    apb(1'b1, `VSW_HREG_CTRL, 32'h3001);
    repeat (4) @(posedge mclk);
    out_chk(3'h0, 3'h0);
    for (int k = 0; k < 8; k++) begin
      cmd(1'b1, 5'h00, 8'(k));
      cmd(1'b1, 5'h01, 8'(7 - k));
      chk(32'(rd[1]), 32'h0);
      repeat (2) @(posedge mclk);
      out_chk(3'(k), 3'(7 - k));
    end
    cmd(1'b0, 5'h00, 8'h00);
    chk(32'(rd[15:8]), 32'h7);
    chk(32'({powered_down, serial_mode}), 32'h1);
  endtask : t_serial

  task automatic t_pd_clear();
    apb(1'b1, `VSW_HREG_CTRL, 32'h3000);
    repeat (4) @(posedge mclk);
    out_chk(3'h0, 3'h0);
    apb(1'b1, `VSW_HREG_CTRL, 32'h3001);
    poll(3, 1'b1);
    repeat (4) @(posedge mclk);
    out_chk(3'h0, 3'h0);
    cmd(1'b0, 5'h00, 8'h00);
    chk(32'(rd[15:8]), 32'h0);
  endtask : t_pd_clear

  task automatic t_filter();
    apb(1'b1, `VSW_HREG_CTRL, 32'h2001);
    repeat (5) @(posedge mclk);
    chk(32'({bus_clk_clean, bus_data_clean}), 32'h1);
    apb(1'b1, `VSW_HREG_CTRL, 32'h1001);
    repeat (5) @(posedge mclk);
    chk(32'({bus_clk_clean, bus_data_clean}), 32'h2);
  endtask : t_filter

  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_parallel();
    t_serial();
    t_pd_clear();
    t_filter();
    finish_test();
  end
endmodule : tb_video_switch_mode_control
